// *** design/ess_sequencer.sv ***
// Functional notes
// R1: Instruction N moves N+1 bytes from address.
// R2: Store instruction byte, pointer plus one.
// R3: Store two address bytes, pointer plus two.
// R4: Copy bytes, append checksum, pointer plus count+1.
// R5: Entry 0 defaults 0x0E at 0x0520.
// R6: Entry 1 defaults 0x33 at 0x0540, 52 bytes.
// R7: Entry 2 defaults 0x17 at 0x0800, 24 bytes.
// R8: Entries processed strictly in ascending order.
`timescale 1ns/1ps

module ess_sequencer #(
  parameter int unsigned STORE_AW = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] map_rd_addr,
  input wire logic [7:0] map_rd_data,
  output logic store_wr_valid,
  input wire logic store_wr_ready,
  output logic [STORE_AW-1:0] store_wr_addr,
  output logic [7:0] store_wr_data
);

  typedef enum logic [2:0] {
    S_IDLE, S_INSTR, S_ADDR_HI, S_ADDR_LO, S_FETCH, S_DATA, S_CSUM
  } ess_state_e;

  localparam int unsigned PW = STORE_AW + 8;
  localparam logic [3:0] NO_SLOT = 4'hF;

  initial begin
    if (STORE_AW < 8 || STORE_AW > 16) $error("ess_sequencer: STORE_AW out of 8..16");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] seq_slot(input logic [15:0] a);
    logic [13:0] idx;
    idx = a[15:2];
    if (idx >= ess_pkg::IDX_SEQ_ANALOG_PLL_B_INSTRUCTION &&
        idx < ess_pkg::IDX_SEQ_ANALOG_PLL_B_INSTRUCTION + 14'(ess_pkg::SEQ_BYTES))
      return 4'(idx - ess_pkg::IDX_SEQ_ANALOG_PLL_B_INSTRUCTION);
    return NO_SLOT;
  endfunction

  function automatic logic [3:0] ent_byte(input logic [1:0] e, input logic [1:0] k);
    return 4'(e * ess_pkg::ENTRY_BYTES + k);
  endfunction

  function automatic logic [7:0] seq_reset(input int unsigned s);
    case (s)
      0: return ess_pkg::RST_ANALOG_PLL_B_INSTR;
      1: return ess_pkg::RST_ANALOG_PLL_B_ADDR[15:8];
      2: return ess_pkg::RST_ANALOG_PLL_B_ADDR[7:0];
      3: return ess_pkg::RST_DIGITAL_PLL_B_INSTR;
      4: return ess_pkg::RST_DIGITAL_PLL_B_ADDR[15:8];
      5: return ess_pkg::RST_DIGITAL_PLL_B_ADDR[7:0];
      6: return ess_pkg::RST_LOOP_FILTER_INSTR;
      7: return ess_pkg::RST_LOOP_FILTER_ADDR[15:8];
      default: return ess_pkg::RST_LOOP_FILTER_ADDR[7:0];
    endcase
  endfunction

  // ****************************************
  // Bus slave and store buffer
  // ****************************************
  ess_reg_if reg_bus();
  ess_stream_if #(.W(PW)) push_s();
  ess_stream_if #(.W(PW)) pop_s();

  ess_axil_slave u_bus (
    .sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .regs(reg_bus.regs)
  );

  ess_fifo2 #(.W(PW)) u_buf (
    .sys_clk(sys_clk), .rst(rst), .in_s(push_s.snk), .out_s(pop_s.src)
  );

  assign store_wr_valid = pop_s.valid;
  assign pop_s.ready = store_wr_ready;
  assign store_wr_addr = pop_s.data[PW-1:8];
  assign store_wr_data = pop_s.data[7:0];

  // ****************************************
  // Register file
  // ****************************************
  ess_state_e state_q, state_d;
  logic [7:0] seq_q [ess_pkg::SEQ_BYTES];
  logic [7:0] seq_d [ess_pkg::SEQ_BYTES];
  logic [STORE_AW-1:0] ptr_q, ptr_d;
  logic done_q, done_d;
  logic busy, wr_ok, start, lane0;
  logic [3:0] wslot, rslot;
  logic [13:0] widx, ridx;

  assign busy = (state_q != S_IDLE);
  assign widx = reg_bus.waddr[15:2];
  assign ridx = reg_bus.raddr[15:2];
  assign wslot = seq_slot(reg_bus.waddr);
  assign rslot = seq_slot(reg_bus.raddr);
  assign lane0 = reg_bus.wstrb[0];
  // Bus writes to sequence, pointer and start are dropped while a run is under way
  assign wr_ok = reg_bus.wr & lane0 & ~busy;
  assign start = wr_ok & (widx == ess_pkg::IDX_CTRL) &
    reg_bus.wdata[ess_pkg::CTRL_START_BIT];
  assign reg_bus.wr_err = (wslot == NO_SLOT) && (widx != ess_pkg::IDX_CTRL) &&
    (widx != ess_pkg::IDX_STATUS) && (widx != ess_pkg::IDX_STORE_PTR);

  always_comb begin
    reg_bus.rdata = 32'h00000000;
    reg_bus.rd_err = 1'b0;
    if (rslot != NO_SLOT) begin
      reg_bus.rdata[7:0] = seq_q[rslot];
    end else if (ridx == ess_pkg::IDX_STATUS) begin
      reg_bus.rdata[ess_pkg::STATUS_BUSY_BIT] = busy;
      reg_bus.rdata[ess_pkg::STATUS_DONE_BIT] = done_q;
    end else if (ridx == ess_pkg::IDX_STORE_PTR) begin
      reg_bus.rdata[STORE_AW-1:0] = ptr_q;
    end else if (ridx != ess_pkg::IDX_CTRL) begin
      reg_bus.rd_err = 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < ess_pkg::SEQ_BYTES; i++) begin
      seq_d[i] = seq_q[i];
    end
    if (wr_ok && wslot != NO_SLOT) seq_d[wslot] = reg_bus.wdata[7:0];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ess_pkg::SEQ_BYTES; i++) begin
        seq_q[i] <= seq_reset(i); // see R5 see R6 see R7
      end
    end else begin
      for (int i = 0; i < ess_pkg::SEQ_BYTES; i++) begin
        seq_q[i] <= seq_d[i];
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  logic [1:0] entry_q, entry_d;
  logic [7:0] cnt_q, cnt_d, sum_q, sum_d;
  logic [15:0] map_addr_q, map_addr_d;
  logic [7:0] instr, addr_hi, addr_lo;
  logic fire;

  assign instr = seq_q[ent_byte(entry_q, 2'h0)];
  assign addr_hi = seq_q[ent_byte(entry_q, 2'h1)];
  assign addr_lo = seq_q[ent_byte(entry_q, 2'h2)];
  assign fire = push_s.valid & push_s.ready;
  assign map_rd_addr = map_addr_q;

  always_comb begin
    state_d = state_q;
    entry_d = entry_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    map_addr_d = map_addr_q;
    done_d = done_q;
    ptr_d = fire ? ptr_q + 1'b1 : ptr_q; // see R2 see R3 see R4
    push_s.valid = 1'b0;
    push_s.data = {ptr_q, 8'h00};
    if (wr_ok && widx == ess_pkg::IDX_STORE_PTR) ptr_d = reg_bus.wdata[STORE_AW-1:0];
    case (state_q)
      S_IDLE: begin
        if (start) begin
          state_d = S_INSTR;
          entry_d = 2'h0;
          done_d = 1'b0;
        end
      end
      S_INSTR: begin
        push_s.valid = 1'b1;
        push_s.data = {ptr_q, instr}; // see R2
        cnt_d = 8'h00;
        sum_d = 8'h00;
        if (fire) state_d = S_ADDR_HI;
      end
      S_ADDR_HI: begin
        push_s.valid = 1'b1;
        push_s.data = {ptr_q, addr_hi}; // see R3
        if (fire) state_d = S_ADDR_LO;
      end
      S_ADDR_LO: begin
        push_s.valid = 1'b1;
        push_s.data = {ptr_q, addr_lo}; // see R3
        if (fire) begin
          map_addr_d = {addr_hi, addr_lo}; // see R1
          state_d = S_FETCH;
        end
      end
      S_FETCH: state_d = S_DATA;
      S_DATA: begin
        push_s.valid = 1'b1;
        push_s.data = {ptr_q, map_rd_data}; // see R4
        if (fire) begin
          sum_d = sum_q + map_rd_data;
          if (cnt_q == instr) begin
            state_d = S_CSUM; // see R1
          end else begin
            cnt_d = cnt_q + 8'h01;
            map_addr_d = map_addr_q + 16'h0001;
            state_d = S_FETCH;
          end
        end
      end
      S_CSUM: begin
        push_s.valid = 1'b1;
        push_s.data = {ptr_q, sum_q}; // see R4
        if (fire) begin
          if (entry_q == 2'(ess_pkg::NUM_ENTRIES - 1)) begin
            state_d = S_IDLE;
            done_d = 1'b1;
          end else begin
            entry_d = entry_q + 2'h1; // see R8
            state_d = S_INSTR;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      entry_q <= 2'h0;
      cnt_q <= 8'h00;
      sum_q <= 8'h00;
      map_addr_q <= 16'h0000;
      ptr_q <= '0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      entry_q <= entry_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      map_addr_q <= map_addr_d;
      ptr_q <= ptr_d;
      done_q <= done_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [STORE_AW-1:0] grp_base_q;
  logic [8:0] grp_data_q;
  logic wrote_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      grp_base_q <= '0;
      grp_data_q <= 9'h000;
      wrote_q <= 1'b0;
    end else begin
      if (state_q == S_INSTR && fire) grp_base_q <= ptr_q;
      if (state_q == S_INSTR) grp_data_q <= 9'h000;
      else if (state_q == S_DATA && fire) grp_data_q <= grp_data_q + 9'h001;
      if (reg_bus.wr) wrote_q <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_group_count: assert property ( // see R1
    state_q == S_CSUM |-> grp_data_q == 9'(instr) + 9'h001)
    else $error("data byte count differs from instruction plus one");
  a_fetch_address: assert property ( // see R1
    state_q == S_DATA |-> map_rd_addr == {addr_hi, addr_lo} + 16'(cnt_q))
    else $error("map read address not start plus count");
  a_instr_byte: assert property ( // see R2
    state_q == S_INSTR && fire |-> push_s.data[7:0] == instr ##1 ptr_q == grp_base_q + 1'b1)
    else $error("instruction byte or pointer step wrong");
  a_addr_span: assert property ( // see R3
    state_q == S_ADDR_LO && fire |=> ptr_q == grp_base_q + STORE_AW'(3) &&
      map_addr_q == {$past(addr_hi), $past(addr_lo)})
    else $error("address bytes not stored or pointer not advanced by two");
  a_group_span: assert property ( // see R4
    state_q == S_CSUM && fire |=>
      ptr_q == grp_base_q + STORE_AW'(3) + STORE_AW'($past(instr)) + STORE_AW'(2))
    else $error("group did not advance pointer by count plus one");
  a_entry0_reset: assert property ( // see R5
    !wrote_q |-> seq_q[0] == 8'h0E && {seq_q[1], seq_q[2]} == 16'h0520)
    else $error("first entry default wrong");
  a_entry1_reset: assert property ( // see R6
    !wrote_q |-> seq_q[3] == 8'h33 && {seq_q[4], seq_q[5]} == 16'h0540)
    else $error("second entry default wrong");
  a_entry2_reset: assert property ( // see R7
    !wrote_q |-> seq_q[6] == 8'h17 && {seq_q[7], seq_q[8]} == 16'h0800)
    else $error("third entry default wrong");
  a_entry_order: assert property ( // see R8
    state_q == S_CSUM && fire && entry_q != 2'h2 |=>
      state_q == S_INSTR && entry_q == $past(entry_q) + 2'h1)
    else $error("entries not taken in ascending order");

  c_full_run: cover property (state_q == S_CSUM && fire && entry_q == 2'h2);
  c_data_stall: cover property (state_q == S_DATA && !push_s.ready);
  c_store_stall: cover property ((store_wr_valid && !store_wr_ready) [*3]);

endmodule // ess_sequencer

// *** design/ess_pkg.sv ***
package ess_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam int unsigned IDX_W = 14;
  localparam logic [13:0] IDX_SEQ_ANALOG_PLL_B_INSTRUCTION = 14'h0E33;
  localparam logic [13:0] IDX_SEQ_ANALOG_PLL_B_START_ADDRESS = 14'h0E34;
  localparam logic [13:0] IDX_SEQ_DIGITAL_PLL_B_DIVIDER_INSTRUCTION = 14'h0E36;
  localparam logic [13:0] IDX_SEQ_DIGITAL_PLL_B_DIVIDER_START_ADDRESS = 14'h0E37;
  localparam logic [13:0] IDX_SEQ_LOOP_FILTER_INSTRUCTION = 14'h0E39;
  localparam logic [13:0] IDX_SEQ_LOOP_FILTER_START_ADDRESS = 14'h0E3A;
  localparam logic [13:0] IDX_CTRL = 14'h0E50;
  localparam logic [13:0] IDX_STATUS = 14'h0E51;
  localparam logic [13:0] IDX_STORE_PTR = 14'h0E52;

  // ****************************************
  // Sequence layout
  // ****************************************
  localparam int unsigned NUM_ENTRIES = 3;
  localparam int unsigned ENTRY_BYTES = 3;
  localparam int unsigned SEQ_BYTES = 9;
  localparam int unsigned ADDR_BYTES = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_ANALOG_PLL_B_INSTR = 8'h0E;
  localparam logic [15:0] RST_ANALOG_PLL_B_ADDR = 16'h0520;
  localparam logic [7:0] RST_DIGITAL_PLL_B_INSTR = 8'h33;
  localparam logic [15:0] RST_DIGITAL_PLL_B_ADDR = 16'h0540;
  localparam logic [7:0] RST_LOOP_FILTER_INSTR = 8'h17;
  localparam logic [15:0] RST_LOOP_FILTER_ADDR = 16'h0800;

  // ****************************************
  // Fields and bus answers
  // ****************************************
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_DONE_BIT = 1;
  localparam int unsigned AXI_AW = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** design/ess_ifs.sv ***
`timescale 1ns/1ps

// ****************************************
// Register access strobes
// ****************************************
interface ess_reg_if;
  logic wr;
  logic [15:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_err;
  logic rd;
  logic [15:0] raddr;
  logic [31:0] rdata;
  logic rd_err;
  modport bus (output wr, waddr, wdata, wstrb, rd, raddr, input wr_err, rdata, rd_err);
  modport regs (input wr, waddr, wdata, wstrb, rd, raddr, output wr_err, rdata, rd_err);
endinterface

// ****************************************
// Valid/ready byte stream
// ****************************************
interface ess_stream_if #(parameter int unsigned W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, data, input ready);
  modport snk (input valid, data, output ready);
endinterface

// *** design/ess_fifo2.sv ***
`timescale 1ns/1ps

module ess_fifo2 #(
  parameter int unsigned W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  ess_stream_if.snk in_s,
  ess_stream_if.src out_s
);

  logic [W-1:0] head_q, head_d, tail_q, tail_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  initial begin
    if (W < 1) $error("ess_fifo2: W must be at least 1");
  end

  // Head is always the oldest word, so output data comes straight from a flop
  assign in_s.ready = (cnt_q != 2'h2);
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data = head_q;
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_comb begin
    head_d = head_q;
    tail_d = tail_q;
    cnt_d = cnt_q;
    case ({push, pop})
      2'b10: begin
        if (cnt_q == 2'h0) head_d = in_s.data;
        else tail_d = in_s.data;
        cnt_d = cnt_q + 2'h1;
      end
      2'b01: begin
        head_d = tail_q;
        cnt_d = cnt_q - 2'h1;
      end
      2'b11: begin
        if (cnt_q == 2'h1) begin
          head_d = in_s.data;
        end else begin
          head_d = tail_q;
          tail_d = in_s.data;
        end
      end
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      head_q <= '0;
      tail_q <= '0;
      cnt_q <= 2'h0;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      cnt_q <= cnt_d;
    end
  end

endmodule // ess_fifo2

// *** design/ess_axil_slave.sv ***
`timescale 1ns/1ps

module ess_axil_slave (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  ess_reg_if.bus regs
);

  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [15:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic aw_take, w_take, ar_take;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;

  // Write fires once both address and data are held or arriving
  assign regs.wr = (aw_hold_q | aw_take) & (w_hold_q | w_take);
  assign regs.waddr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  assign regs.wdata = w_hold_q ? w_data_q : s_axi_wdata;
  assign regs.wstrb = w_hold_q ? w_strb_q : s_axi_wstrb;
  assign regs.rd = ar_take;
  assign regs.raddr = s_axi_araddr;

  always_comb begin
    aw_hold_d = aw_hold_q | aw_take;
    aw_addr_d = aw_take ? s_axi_awaddr : aw_addr_q;
    w_hold_d = w_hold_q | w_take;
    w_data_d = w_take ? s_axi_wdata : w_data_q;
    w_strb_d = w_take ? s_axi_wstrb : w_strb_q;
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d = bresp_q;
    if (regs.wr) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = regs.wr_err ? ess_pkg::RESP_SLVERR : ess_pkg::RESP_OKAY;
    end
    rvalid_d = rvalid_q & ~s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d = regs.rdata;
      rresp_d = regs.rd_err ? ess_pkg::RESP_SLVERR : ess_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 16'h0000;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q <= w_hold_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule // ess_axil_slave

// *** tb/ess_store_model.sv ***
`timescale 1ns/1ps

// ****************************************
// Register map and store stand-in
// ****************************************
module ess_store_model #(
  parameter int unsigned STORE_AW = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stall_mode,
  input wire logic [15:0] map_rd_addr,
  output logic [7:0] map_rd_data,
  input wire logic store_wr_valid,
  output logic store_wr_ready,
  input wire logic [STORE_AW-1:0] store_wr_addr,
  input wire logic [7:0] store_wr_data
);
  logic [7:0] mem [0:(1<<STORE_AW)-1];
  logic [1:0] phase_q;

  assign map_rd_data = map_rd_addr[7:0] ^ map_rd_addr[15:8] ^ 8'h5A;

  // Slow mode accepts one word in four cycles
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 2'h0;
      store_wr_ready <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      store_wr_ready <= !stall_mode || (phase_q == 2'h3);
      if (store_wr_valid && store_wr_ready) begin
        mem[store_wr_addr] <= store_wr_data;
      end
    end
  end
endmodule // ess_store_model

// *** tb/eeprom_store_sequencer_pll1_tb.sv ***
`timescale 1ns/1ps

// ****************************************
// Sequencer bench
// ****************************************
module eeprom_store_sequencer_pll1_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] awaddr = 16'h0000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [15:0] araddr = 16'h0000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [15:0] map_addr;
  logic [7:0] map_data;
  logic st_valid;
  logic st_ready;
  logic [9:0] st_addr;
  logic [7:0] st_data;
  logic stall_mode = 1'b0;
  int failures = 0;
  int samples_checked = 0;
  logic [7:0] instr_e [3];
  logic [15:0] addr_e [3];
  logic [31:0] rd_v;
  logic [1:0] resp_v;
  logic [7:0] rst_tab [9] = '{8'h0E, 8'h05, 8'h20, 8'h33, 8'h05, 8'h40, 8'h17, 8'h08, 8'h00};
  logic [7:0] wr_tab [9] = '{8'h00, 8'h12, 8'hFF, 8'h33, 8'h05, 8'h40, 8'h02, 8'h07, 8'hFE};

  always #50 sys_clk = ~sys_clk;

  ess_sequencer #(.STORE_AW(10)) ess_sequencer_inst (
    .sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .map_rd_addr(map_addr), .map_rd_data(map_data),
    .store_wr_valid(st_valid), .store_wr_ready(st_ready),
    .store_wr_addr(st_addr), .store_wr_data(st_data)
  );

  ess_store_model #(.STORE_AW(10)) ess_store_model_inst (
    .sys_clk(sys_clk), .rst(rst), .stall_mode(stall_mode),
    .map_rd_addr(map_addr), .map_rd_data(map_data),
    .store_wr_valid(st_valid), .store_wr_ready(st_ready),
    .store_wr_addr(st_addr), .store_wr_data(st_data)
  );

  function automatic logic [7:0] mapf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout_hit();
    failures++;
    $display("MISMATCH wait expected answer seen timeout");
    end_sim();
  endtask

  task automatic axi_wr(input logic [13:0] idx, input logic [31:0] val, output logic [1:0] resp);
    int n;
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= val;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    resp = bresp;
    if (n == 50) timeout_hit();
  endtask

  task automatic axi_rd(input logic [13:0] idx, output logic [31:0] data, output logic [1:0] resp);
    int n;
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    data = rdata;
    resp = rresp;
    if (n == 50) timeout_hit();
  endtask

  // Starts one run, then walks the store image entry by entry
  task automatic run_seq(input logic [9:0] p0, input logic stall);
    int n;
    int e;
    int i;
    logic [9:0] p;
    logic [7:0] b;
    logic [7:0] sum;
    axi_wr(ess_pkg::IDX_STORE_PTR, {22'h0, p0}, resp_v);
    stall_mode <= stall;
    axi_wr(ess_pkg::IDX_CTRL, 32'h1, resp_v);
    axi_wr(ess_pkg::IDX_SEQ_ANALOG_PLL_B_INSTRUCTION, 32'h5, resp_v);
    axi_rd(ess_pkg::IDX_STATUS, rd_v, resp_v);
    check("status busy", rd_v, 32'h1);
    for (n = 0; n < 500; n++) begin
      axi_rd(ess_pkg::IDX_STATUS, rd_v, resp_v);
      if (rd_v[1]) break;
    end
    if (n == 500) timeout_hit();
    check("status done", rd_v, 32'h2);
    // Done comes before the buffer has drained into the store
    for (n = 0; n < 50 && st_valid; n++) @(posedge sys_clk);
    if (st_valid) timeout_hit();
    p = p0;
    for (e = 0; e < 3; e++) begin
      sum = 8'h00;
      check("instr", ess_store_model_inst.mem[p], instr_e[e]);
      check("addr hi", ess_store_model_inst.mem[p+1], addr_e[e][15:8]);
      check("addr lo", ess_store_model_inst.mem[p+2], addr_e[e][7:0]);
      p = p + 10'd3;
      for (i = 0; i <= int'(instr_e[e]); i++) begin
        b = mapf(addr_e[e] + 16'(i));
        sum = sum + b;
        check("data", ess_store_model_inst.mem[p], b);
        p = p + 10'd1;
      end
      check("checksum", ess_store_model_inst.mem[p], sum);
      p = p + 10'd1;
    end
    axi_rd(ess_pkg::IDX_STORE_PTR, rd_v, resp_v);
    check("store ptr", rd_v, {22'h0, p});
    axi_rd(ess_pkg::IDX_SEQ_ANALOG_PLL_B_INSTRUCTION, rd_v, resp_v);
    check("busy write kept out", rd_v, {24'h0, instr_e[0]});
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      axi_rd(14'h0E33 + 14'(k), rd_v, resp_v);
      check("seq reset value", rd_v, {24'h0, rst_tab[k]});
    end
    axi_rd(14'h0E60, rd_v, resp_v);
    check("unmapped rresp", {30'h0, resp_v}, {30'h0, ess_pkg::RESP_SLVERR});
    axi_wr(14'h0E60, 32'hFF, resp_v);
    check("unmapped bresp", {30'h0, resp_v}, {30'h0, ess_pkg::RESP_SLVERR});
    wstrb <= 4'h0;
    axi_wr(ess_pkg::IDX_SEQ_LOOP_FILTER_INSTRUCTION, 32'hAA, resp_v);
    wstrb <= 4'hF;
    check("masked bresp", {30'h0, resp_v}, {30'h0, ess_pkg::RESP_OKAY});
    axi_rd(ess_pkg::IDX_SEQ_LOOP_FILTER_INSTRUCTION, rd_v, resp_v);
    check("masked write kept out", rd_v, {24'h0, ess_pkg::RST_LOOP_FILTER_INSTR});
    $display("test reset_values done");
    instr_e = '{8'h0E, 8'h33, 8'h17};
    addr_e = '{16'h0520, 16'h0540, 16'h0800};
    run_seq(10'h000, 1'b0);
    $display("test default_run done");
    for (int k = 0; k < 9; k++) begin
      axi_wr(14'h0E33 + 14'(k), {24'h0, wr_tab[k]}, resp_v);
    end
    instr_e = '{8'h00, 8'h33, 8'h02};
    addr_e = '{16'h12FF, 16'h0540, 16'h07FE};
    run_seq(10'h100, 1'b1);
    $display("test stalled_run done");
    end_sim();
  end
endmodule // eeprom_store_sequencer_pll1_tb
